//--- hdl/diomm_in_sync.sv
// Two-stage synchroniser and rising-edge detector for the three control inputs
`timescale 1ns/100ps
`default_nettype none
module diomm_in_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Pins
  input wire logic [2:0] pin_in,
  // Synchronised level and leading-edge pulse
  output logic [2:0] level_out,
  output logic [2:0] rise_out
);

  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      prev_q <= 3'h0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  // RL15: leading edge detect
  assign rise_out = sync_q & ~prev_q;

endmodule
`default_nettype wire

//--- hdl/diomm_pkg.sv
// Package for the digital I/O mode mapper: modes, carriers and reset values
package diomm_pkg;

  // ***************************************************************
  // Mode encodings
  // ***************************************************************
  localparam logic [2:0] DIOMM_OUT_MODE_MAX = 3'h5;
  localparam logic [2:0] DIOMM_IN_MODE_MAX = 3'h4;
  localparam logic [2:0] DIOMM_MODE_KEEP = 3'h5;
  localparam logic [2:0] DIOMM_MODE_LINKED = 3'h4;
  localparam logic [2:0] DIOMM_MODE_RST = 3'h0;

  typedef enum logic [2:0] {
    DIOMM_M0 = 3'h0,
    DIOMM_M1 = 3'h1,
    DIOMM_M2 = 3'h2,
    DIOMM_M3 = 3'h3,
    DIOMM_M4 = 3'h4,
    DIOMM_M5 = 3'h5
  } diomm_mode_type;

  // ***************************************************************
  // Function selectors for the local per-function assignment
  // ***************************************************************
  // Each function names the input (1..3) that triggers it, 0 = none
  localparam int DIOMM_NFUNC = 6;
  localparam int DIOMM_F_PERIOD = 0;
  localparam int DIOMM_F_START = 1;
  localparam int DIOMM_F_STOP = 2;
  localparam int DIOMM_F_CLRMM = 3;
  localparam int DIOMM_F_TXVAL = 4;
  localparam int DIOMM_F_MSTART = 5;
  localparam logic [1:0] DIOMM_SEL_NONE = 2'h0;
  localparam logic [1:0] DIOMM_SEL_RST = 2'h0;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic running;
    logic complete;
    logic in_tol;
    logic good;
    logic warn_out;
    logic tol_out;
    logic rework;
    logic reject;
    logic below_lwarn;
    logic above_uwarn;
  } diomm_meas_type;

  typedef struct packed {
    logic period;
    logic start;
    logic stop;
    logic clr_minmax;
    logic tx_value;
    logic master_start;
    logic master_take;
  } diomm_func_type;

  typedef struct packed {
    logic [1:0] period;
    logic [1:0] start;
    logic [1:0] stop;
    logic [1:0] clr_minmax;
    logic [1:0] tx_value;
    logic [1:0] master_start;
  } diomm_assign_type;

endpackage

//--- hdl/diomm_top.sv
// Digital I/O mode mapper: output mode mapping and input function decoding
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RL1: three outputs modes 0-5, three inputs 0-4
// RL2: output mode 0 drives nothing
// RL3: mode 1: running, complete, within limits
// RL4: mode 2: good, warning exceeded, tolerance exceeded
// RL5: mode 3: good, rework, reject
// RL6: mode 4 same outputs as mode 3
// RL7: mode 5: good, below lower warning
// RL8: mode 5 above upper warning on three
// RL9: mode 4 on either side forces both; output mode 4 does not end an active local assignment
// RL10: input mode 0 ignores all inputs
// RL11: mode 1 levels: period, master start, takeover
// RL12: mode 2 pulses start, stop; clear min/max
// RL13: mode 3 period, send pulse, master start+take
// RL14: mode 4 period level, master start/take pulses
// RL15: status levels sustained, pulses on leading edge
// RL16: program preset mode overrides local assignment
// RL17: report mode 5 if local assignment nonstandard
// RL18: returned mode 5 keeps local assignment
module diomm_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Local mode selection from the instrument front panel
  input wire logic [2:0] loc_out_mode_in,
  input wire logic loc_out_mode_wr_in,
  input wire logic [2:0] loc_in_mode_in,
  input wire logic loc_in_mode_wr_in,
  // Local per-function input assignment
  input wire diomm_pkg::diomm_assign_type loc_assign_in,
  input wire logic loc_assign_wr_in,
  // Configuration program
  input wire logic [2:0] cfg_in_mode_in,
  input wire logic cfg_in_mode_wr_in,
  input wire logic [2:0] cfg_out_mode_in,
  input wire logic cfg_out_mode_wr_in,
  output logic [2:0] upload_in_mode_out,
  // Measurement state
  input wire diomm_pkg::diomm_meas_type meas_in,
  // Control pins
  input wire logic input_line_one_in,
  input wire logic input_line_two_in,
  input wire logic input_line_three_in,
  output logic output_line_one_out,
  output logic output_line_two_out,
  output logic output_line_three_out,
  // Decoded instrument functions
  output diomm_pkg::diomm_func_type func_out,
  output logic [2:0] out_mode_out,
  output logic [2:0] in_mode_out
);

  // ***************************************************************
  // Mode storage
  // ***************************************************************
  logic [2:0] out_mode_q;
  logic [2:0] in_mode_q;
  logic custom_q;
  diomm_pkg::diomm_assign_type assign_q;

  // RL1: modes out of range are refused
  logic loc_out_ok;
  logic loc_in_ok;
  logic cfg_out_ok;
  logic cfg_in_ok;
  // Out-of-range writes are dropped silently rather than clamped
  assign loc_out_ok = loc_out_mode_wr_in && loc_out_mode_in <= diomm_pkg::DIOMM_OUT_MODE_MAX;
  assign loc_in_ok = loc_in_mode_wr_in && loc_in_mode_in <= diomm_pkg::DIOMM_IN_MODE_MAX;
  assign cfg_out_ok = cfg_out_mode_wr_in && cfg_out_mode_in <= diomm_pkg::DIOMM_OUT_MODE_MAX;
  // RL18: mode 5 from the program is not applied
  assign cfg_in_ok = cfg_in_mode_wr_in && cfg_in_mode_in <= diomm_pkg::DIOMM_IN_MODE_MAX;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_mode_q <= diomm_pkg::DIOMM_MODE_RST;
      in_mode_q <= diomm_pkg::DIOMM_MODE_RST;
    end else begin
      // RL9: mode 4 on either side links both
      // Leaving mode 4 on one side does not move the other side back
      if (cfg_in_ok) begin
        in_mode_q <= cfg_in_mode_in;
        if (cfg_in_mode_in == diomm_pkg::DIOMM_MODE_LINKED) begin
          out_mode_q <= diomm_pkg::DIOMM_MODE_LINKED;
        end
      end else if (loc_in_ok) begin
        in_mode_q <= loc_in_mode_in;
        if (loc_in_mode_in == diomm_pkg::DIOMM_MODE_LINKED) begin
          out_mode_q <= diomm_pkg::DIOMM_MODE_LINKED;
        end
      end else if (cfg_out_ok) begin
        out_mode_q <= cfg_out_mode_in;
        if (cfg_out_mode_in == diomm_pkg::DIOMM_MODE_LINKED) begin
          in_mode_q <= diomm_pkg::DIOMM_MODE_LINKED;
        end
      end else if (loc_out_ok) begin
        out_mode_q <= loc_out_mode_in;
        if (loc_out_mode_in == diomm_pkg::DIOMM_MODE_LINKED) begin
          in_mode_q <= diomm_pkg::DIOMM_MODE_LINKED;
        end
      end
    end
  end

  // Local custom assignment is kept until a preset mode replaces it
  // An input mode write beats an assignment write in the same cycle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      custom_q <= 1'b0;
      assign_q <= '0;
    end else if (cfg_in_ok) begin
      // RL16: program preset discards local assignment
      custom_q <= 1'b0;
    end else if (loc_in_ok) begin
      custom_q <= 1'b0;
    end else if (loc_assign_wr_in) begin
      custom_q <= 1'b1;
      assign_q <= loc_assign_in;
    end
  end

  // Upload value lags one cycle; the program reads it only at upload time
  // RL17: nonstandard assignment reported as mode 5
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      upload_in_mode_out <= diomm_pkg::DIOMM_MODE_RST;
    end else if (custom_q) begin
      upload_in_mode_out <= diomm_pkg::DIOMM_MODE_KEEP;
    end else begin
      upload_in_mode_out <= in_mode_q;
    end
  end

  assign out_mode_out = out_mode_q;
  assign in_mode_out = in_mode_q;

  // ***************************************************************
  // Output mapping
  // ***************************************************************
  logic [2:0] out_d;
  logic [2:0] out_q;

  always_comb begin
    out_d = 3'h0;
    case (diomm_pkg::diomm_mode_type'(out_mode_q))
      // RL2: nothing driven
      diomm_pkg::DIOMM_M0: begin
        out_d = 3'h0;
      end
      // RL3: running, complete, in limits
      diomm_pkg::DIOMM_M1: begin
        out_d = {meas_in.in_tol, meas_in.complete, meas_in.running};
      end
      // RL4: good, warning, tolerance
      diomm_pkg::DIOMM_M2: begin
        out_d = {meas_in.tol_out, meas_in.warn_out, meas_in.good};
      end
      // RL5: classification, RL6: mode 4 shares it
      diomm_pkg::DIOMM_M3, diomm_pkg::DIOMM_M4: begin
        out_d = {meas_in.reject, meas_in.rework, meas_in.good};
      end
      // RL7: good and below lower warning, RL8: upper on three
      diomm_pkg::DIOMM_M5: begin
        out_d = {meas_in.above_uwarn, meas_in.below_lwarn, meas_in.good};
      end
      default: begin
        out_d = 3'h0;
      end
    endcase
  end

  // Registered so the isolated outputs never glitch while mode or state settle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_q <= 3'h0;
    end else begin
      out_q <= out_d;
    end
  end

  assign output_line_one_out = out_q[0];
  assign output_line_two_out = out_q[1];
  assign output_line_three_out = out_q[2];

  // ***************************************************************
  // Input decoding
  // ***************************************************************
  logic [2:0] lvl;
  logic [2:0] rise;

  diomm_in_sync u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in({input_line_three_in, input_line_two_in, input_line_one_in}),
    .level_out(lvl),
    .rise_out(rise)
  );

  // Picks an input bit by its 1-based selector, 0 means unassigned
  function automatic logic pick(input logic [2:0] v, input logic [1:0] sel);
    logic r;
    r = 1'b0;
    if (sel != diomm_pkg::DIOMM_SEL_NONE) begin
      r = v[sel - 2'h1];
    end
    return r;
  endfunction

  diomm_pkg::diomm_func_type func_d;

  always_comb begin
    func_d = '0;
    if (custom_q) begin
      // Takeover cannot be assigned locally, so it stays quiet here
      // RL15: levels for period, pulses elsewhere
      func_d.period = pick(lvl, assign_q.period);
      func_d.start = pick(rise, assign_q.start);
      func_d.stop = pick(rise, assign_q.stop);
      func_d.clr_minmax = pick(rise, assign_q.clr_minmax);
      func_d.tx_value = pick(rise, assign_q.tx_value);
      func_d.master_start = pick(rise, assign_q.master_start);
    end else begin
      case (diomm_pkg::diomm_mode_type'(in_mode_q))
        // RL10: all inputs ignored
        diomm_pkg::DIOMM_M0: begin
          func_d = '0;
        end
        // RL11: all level interpreted
        diomm_pkg::DIOMM_M1: begin
          func_d.period = lvl[0];
          func_d.master_start = lvl[1];
          func_d.master_take = lvl[2];
        end
        // RL12: start/stop pulses, clear level
        diomm_pkg::DIOMM_M2: begin
          func_d.start = rise[0];
          func_d.stop = rise[1];
          func_d.clr_minmax = lvl[2];
        end
        // RL13: period, send pulse, master start and take
        diomm_pkg::DIOMM_M3: begin
          func_d.period = lvl[0];
          func_d.tx_value = rise[1];
          func_d.master_start = lvl[2];
          func_d.master_take = lvl[2];
        end
        // RL14: period level, master pulses
        diomm_pkg::DIOMM_M4: begin
          func_d.period = lvl[0];
          func_d.master_start = rise[1];
          func_d.master_take = rise[2];
        end
        default: begin
          func_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      func_out <= '0;
    end else begin
      func_out <= func_d;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_mode_zero_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL2
    $past(out_mode_q) == 3'h0 |-> out_q == 3'h0) else $error("output mode 0 drives a line");
  a_mode_one_map: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL3
    $past(out_mode_q) == 3'h1 |-> out_q == {$past(meas_in.in_tol), $past(meas_in.complete),
    $past(meas_in.running)}) else $error("output mode 1 mapping wrong");
  a_mode_two_map: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL4
    $past(out_mode_q) == 3'h2 |-> out_q == {$past(meas_in.tol_out), $past(meas_in.warn_out),
    $past(meas_in.good)}) else $error("output mode 2 mapping wrong");
  a_class_map: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL5
    ($past(out_mode_q) == 3'h3 || $past(out_mode_q) == 3'h4) |-> out_q == {$past(meas_in.reject),
    $past(meas_in.rework), $past(meas_in.good)}) else $error("classification mapping wrong");
  a_mode_five_map: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL7
    $past(out_mode_q) == 3'h5 |-> out_q == {$past(meas_in.above_uwarn), $past(meas_in.below_lwarn),
    $past(meas_in.good)}) else $error("output mode 5 mapping wrong");
  a_mode_link: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL9
    (cfg_in_ok && cfg_in_mode_in == 3'h4)
    || (!cfg_in_ok && loc_in_ok && loc_in_mode_in == 3'h4)
    || (!cfg_in_ok && !loc_in_ok && cfg_out_ok && cfg_out_mode_in == 3'h4)
    || (!cfg_in_ok && !loc_in_ok && !cfg_out_ok && loc_out_ok && loc_out_mode_in == 3'h4)
    |=> in_mode_q == 3'h4 && out_mode_q == 3'h4) else $error("mode 4 not linked");
  a_in_zero_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL10
    in_mode_q == 3'h0 && !custom_q |=> func_out == '0) else $error("input mode 0 not ignored");
  a_pulse_once: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL14
    in_mode_q == 3'h4 && !custom_q && $stable(in_mode_q) && func_out.master_take |=> !func_out.master_take)
    else $error("takeover pulse longer than one cycle");
  a_preset_wins: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL16
    cfg_in_ok |=> !custom_q ##1 upload_in_mode_out != 3'h5) else $error("preset did not override");
  a_report_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL17
    custom_q |=> upload_in_mode_out == 3'h5) else $error("custom assignment not reported");
  a_keep_on_five: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL18
    cfg_in_mode_wr_in && cfg_in_mode_in == 3'h5 && !loc_in_ok && !cfg_out_ok && !loc_out_ok
    |=> $stable(in_mode_q)) else $error("mode 5 changed input mode");

  // ***************************************************************
  // Mode bookkeeping checks
  // ***************************************************************
  a_mode_range: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL1
    out_mode_q <= diomm_pkg::DIOMM_OUT_MODE_MAX && in_mode_q <= diomm_pkg::DIOMM_IN_MODE_MAX)
    else $error("mode out of range");
  a_out_refused: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL1
    loc_out_mode_wr_in && loc_out_mode_in > diomm_pkg::DIOMM_OUT_MODE_MAX
    && !cfg_in_ok && !loc_in_ok && !cfg_out_ok |=> $stable(out_mode_q)) else $error("refused output mode applied");
  a_in_refused: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL1
    loc_in_mode_wr_in && loc_in_mode_in > diomm_pkg::DIOMM_IN_MODE_MAX
    && !cfg_in_ok && !cfg_out_ok && !loc_out_ok |=> $stable(in_mode_q)) else $error("refused input mode applied");
  a_upload_std: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL17
    !custom_q |=> upload_in_mode_out == $past(in_mode_q)) else $error("standard mode not reported");
  a_keep_assign: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL18
    cfg_in_mode_wr_in && cfg_in_mode_in == 3'h5 && !loc_in_ok && !loc_assign_wr_in
    |=> $stable(custom_q) && $stable(assign_q)) else $error("mode 5 changed local assignment");

  // ***************************************************************
  // Input function checks
  // ***************************************************************
  a_in_one_map: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL11
    in_mode_q == 3'h1 && !custom_q |=> func_out == {$past(lvl[0]), 4'h0, $past(lvl[1]), $past(lvl[2])})
    else $error("input mode 1 decode wrong");
  a_in_two_map: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL12
    in_mode_q == 3'h2 && !custom_q |=> func_out == {1'b0, $past(rise[0]), $past(rise[1]), $past(lvl[2]), 3'h0})
    else $error("input mode 2 decode wrong");
  a_in_three_map: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL13
    in_mode_q == 3'h3 && !custom_q |=> func_out == {$past(lvl[0]), 3'h0, $past(rise[1]), $past(lvl[2]), $past(lvl[2])})
    else $error("input mode 3 decode wrong");
  a_in_four_map: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL14
    in_mode_q == 3'h4 && !custom_q |=> func_out == {$past(lvl[0]), 4'h0, $past(rise[1]), $past(rise[2])})
    else $error("input mode 4 decode wrong");
  a_custom_take: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL15
    custom_q |=> !func_out.master_take) else $error("takeover raised in custom use");
  a_custom_start: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL15
    custom_q && assign_q.start == 2'h1 |=> func_out.start == $past(rise[0])) else $error("custom start not edge");
  a_custom_period: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL15
    custom_q && assign_q.period == 2'h1 |=> func_out.period == $past(lvl[0])) else $error("custom period not level");

endmodule
`default_nettype wire

//--- tb/diomm_plc_model.sv
// Model of the controller and configuration program facing the mode mapper
`timescale 1ns/100ps
`default_nettype none
module diomm_plc_model (
  // Requests from the bench
  input wire logic [2:0] pin_req_in,
  input wire logic cfg_req_in,
  input wire logic [2:0] cfg_mode_req_in,
  input wire logic keep_local_in,
  // Mode reported by the device during upload
  input wire logic [2:0] upload_in_mode_in,
  // Control pins and program link
  output logic input_line_one_out,
  output logic input_line_two_out,
  output logic input_line_three_out,
  output logic [2:0] cfg_in_mode_out,
  output logic cfg_in_mode_wr_out
);
  // ***************************************************************
  // Pins and program answer
  // ***************************************************************
  // Optocoupler inputs carry no current when not driven, so idle is low
  assign input_line_one_out = pin_req_in[0];
  assign input_line_two_out = pin_req_in[1];
  assign input_line_three_out = pin_req_in[2];
  assign cfg_in_mode_wr_out = cfg_req_in;
  assign cfg_in_mode_out = (keep_local_in && upload_in_mode_in == 3'h5) ? 3'h5 : cfg_mode_req_in;
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the digital I/O mode mapper
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb;
  // ***************************************************************
  // Signals and instances
  // ***************************************************************
  logic clk_in, sys_rst_in;
  logic [2:0] loc_out_mode, loc_in_mode, cfg_out_mode, cfg_in_mode, upload, out_mode, in_mode;
  logic loc_out_wr, loc_in_wr, loc_assign_wr, cfg_out_wr, cfg_in_wr, cfg_req, keep_local;
  logic [2:0] pin_req, cfg_mode_req, lines;
  logic line_one, line_two, line_three;
  diomm_pkg::diomm_assign_type loc_assign;
  diomm_pkg::diomm_meas_type meas;
  diomm_pkg::diomm_func_type func;
  int error_cnt = 0;
  int check_count = 0;
  diomm_plc_model u_diomm_plc_model (.pin_req_in(pin_req), .cfg_req_in(cfg_req), .cfg_mode_req_in(cfg_mode_req),
    .keep_local_in(keep_local), .upload_in_mode_in(upload), .input_line_one_out(line_one),
    .input_line_two_out(line_two), .input_line_three_out(line_three), .cfg_in_mode_out(cfg_in_mode),
    .cfg_in_mode_wr_out(cfg_in_wr));
  diomm_top u_diomm_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .loc_out_mode_in(loc_out_mode),
    .loc_out_mode_wr_in(loc_out_wr), .loc_in_mode_in(loc_in_mode), .loc_in_mode_wr_in(loc_in_wr),
    .loc_assign_in(loc_assign), .loc_assign_wr_in(loc_assign_wr), .cfg_in_mode_in(cfg_in_mode),
    .cfg_in_mode_wr_in(cfg_in_wr), .cfg_out_mode_in(cfg_out_mode), .cfg_out_mode_wr_in(cfg_out_wr),
    .upload_in_mode_out(upload), .meas_in(meas), .input_line_one_in(line_one), .input_line_two_in(line_two),
    .input_line_three_in(line_three), .output_line_one_out(lines[2]), .output_line_two_out(lines[1]),
    .output_line_three_out(lines[0]), .func_out(func), .out_mode_out(out_mode), .in_mode_out(in_mode));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [2:0] exp_lines(logic [2:0] m, diomm_pkg::diomm_meas_type s);
    case (m)
      3'h1: return {s.running, s.complete, s.in_tol};
      3'h2: return {s.good, s.warn_out, s.tol_out};
      3'h3, 3'h4: return {s.good, s.rework, s.reject};
      3'h5: return {s.good, s.below_lwarn, s.above_uwarn};
      default: return 3'h0;
    endcase
  endfunction

  // Write pulse on one cycle, then let two edges land
  task automatic wr_mode(int kind, logic [2:0] m);
    @(negedge clk_in);
    case (kind)
      0: begin loc_out_mode = m; loc_out_wr = 1'b1; end
      1: begin cfg_out_mode = m; cfg_out_wr = 1'b1; end
      2: begin loc_in_mode = m; loc_in_wr = 1'b1; end
      default: begin cfg_mode_req = m; cfg_req = 1'b1; end
    endcase
    @(negedge clk_in);
    {loc_out_wr, cfg_out_wr, loc_in_wr, cfg_req} = 4'h0;
    @(negedge clk_in);
  endtask

  // Hold one pin for eight cycles; levels show six cycles, pulses one
  task automatic pin_chk(int k, logic [6:0] lm, logic [6:0] pm);
    int cnt[7];
    int e;
    foreach (cnt[b]) cnt[b] = 0;
    pin_req[k] = 1'b1;
    repeat (8) begin
      @(negedge clk_in);
      foreach (cnt[b]) cnt[b] += (func[b] === 1'b1) ? 1 : 0;
    end
    pin_req[k] = 1'b0;
    repeat (5) @(negedge clk_in);
    foreach (cnt[b]) begin
      e = lm[b] ? 6 : (pm[b] ? 1 : 0);
      `CHK("func_count", e, cnt[b])
    end
    `CHK("func_idle", 7'h00, func)
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset;
    `CHK("lines_rst", 3'h0, lines)
    `CHK("out_mode_rst", 3'h0, out_mode)
    `CHK("func_rst", 7'h00, func)
  endtask

  task automatic t_out_modes;
    for (int m = 0; m < 6; m++) begin
      wr_mode((m == 5) ? 1 : 0, m[2:0]);
      `CHK("out_mode", m[2:0], out_mode)
      for (int p = 0; p < 11; p++) begin
        meas = (p == 10) ? 10'h3FF : (10'h001 << p);
        @(negedge clk_in);
        `CHK("out_lines", exp_lines(m[2:0], meas), lines)
      end
    end
    wr_mode(0, 3'h6);
    `CHK("out_mode_refused", 3'h5, out_mode)
    meas = 10'h000;
  endtask

  task automatic t_in_modes;
    // Output mode 4 written earlier left the inputs linked in mode 4
    `CHK("in_linked", 3'h4, in_mode)
    wr_mode(2, 3'h0);
    wr_mode(2, 3'h5);
    `CHK("in_mode_refused", 3'h0, in_mode)
    for (int k = 0; k < 3; k++) pin_chk(k, 7'h00, 7'h00);
    wr_mode(2, 3'h1);
    pin_chk(0, 7'h40, 7'h00);
    pin_chk(1, 7'h02, 7'h00);
    pin_chk(2, 7'h01, 7'h00);
    wr_mode(2, 3'h2);
    pin_chk(0, 7'h00, 7'h20);
    pin_chk(1, 7'h00, 7'h10);
    pin_chk(2, 7'h08, 7'h00);
    wr_mode(2, 3'h3);
    pin_chk(0, 7'h40, 7'h00);
    pin_chk(1, 7'h00, 7'h04);
    pin_chk(2, 7'h03, 7'h00);
  endtask

  task automatic t_program;
    @(negedge clk_in);
    loc_assign = '0;
    loc_assign.start = 2'h1;
    loc_assign.period = 2'h1;
    loc_assign_wr = 1'b1;
    @(negedge clk_in);
    loc_assign_wr = 1'b0;
    @(negedge clk_in);
    `CHK("upload_custom", 3'h5, upload)
    pin_chk(0, 7'h40, 7'h20);
    keep_local = 1'b1;
    wr_mode(3, 3'h3);
    `CHK("upload_kept", 3'h5, upload)
    pin_chk(0, 7'h40, 7'h20);
    keep_local = 1'b0;
    wr_mode(3, 3'h2);
    `CHK("in_mode_cfg", 3'h2, in_mode)
    `CHK("upload_std", 3'h2, upload)
    pin_chk(1, 7'h00, 7'h10);
  endtask

  task automatic t_linked;
    wr_mode(0, 3'h4);
    `CHK("in_forced", 3'h4, in_mode)
    wr_mode(2, 3'h1);
    wr_mode(0, 3'h1);
    wr_mode(2, 3'h4);
    `CHK("out_forced", 3'h4, out_mode)
    pin_chk(0, 7'h40, 7'h00);
    pin_chk(1, 7'h00, 7'h02);
    pin_chk(2, 7'h00, 7'h01);
  endtask

  // ***************************************************************
  // Sequence, watchdog and verdict
  // ***************************************************************
  task automatic wrap_up;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    {loc_out_mode, loc_in_mode, cfg_out_mode, cfg_mode_req, pin_req} = 15'h0000;
    {loc_out_wr, loc_in_wr, loc_assign_wr, cfg_out_wr, cfg_req, keep_local} = 6'h00;
    loc_assign = '0;
    meas = 10'h000;
    sys_rst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_out_modes();
    t_in_modes();
    t_program();
    t_linked();
    wrap_up();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
